// *** hw/tdrwa_edge.sv ***
/*
 * Scan-sampled rising edge detector for one request level.
 * Assumes the level and the scan strobe come from logic on core_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module tdrwa_edge (
  input  wire logic core_clk_in,   // Core clock
  input  wire logic rst_in,        // Synchronous reset, high
  input  wire logic scan_in,       // One-cycle scan strobe
  input  wire logic level_in,      // Request level
  output logic      rise_out       // Pulse on first scan seeing high
);

  // ***************************************************************
  // Level seen at the previous scan
  // ***************************************************************
  logic last_r;  // Starts low, so a level high out of reset fires once

  // Updated only on scans, so held inputs never refire
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      last_r <= 1'b0;
    end else if (scan_in) begin
      last_r <= level_in;
    end
  end

  // Combinational pulse, one cycle wide
  assign rise_out = scan_in & level_in & ~last_r;

endmodule

`default_nettype wire

// *** hw/tdrwa_pkg.sv ***
/*
 * Shared constants and carrier types for the time-of-day read, write and
 * adjust block.
 * Assumes a 10 MHz core clock and 16-bit engine data registers.
 */
package tdrwa_pkg;

  // ***************************************************************
  // Clock and timebase
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;            // Core clock period
  localparam int SECOND_NS     = 1_000_000_000;  // One second in ns
  // Core cycles per second of the timebase
  localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

  // ***************************************************************
  // Ranges and reset values
  // ***************************************************************
  localparam logic [15:0] HOUR_MAX     = 16'h0017;  // 23
  localparam logic [15:0] MIN_MAX      = 16'h003B;  // 59
  localparam logic [15:0] SEC_MAX      = 16'h003B;  // 59
  localparam logic [15:0] SEC_ROUND_UP = 16'h001E;  // 30 rounds up
  localparam logic [15:0] RST_HOUR     = 16'h0000;
  localparam logic [15:0] RST_MIN      = 16'h0000;
  localparam logic [15:0] RST_SEC      = 16'h0000;
  localparam logic [15:0] RST_CODE     = 16'h0000;
  // Error code for an out-of-range time write; value is arbitrary
  localparam logic [15:0] ERR_TIME_RANGE = 16'h0074;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  // Three consecutive data registers: base, base+1, base+2
  typedef struct packed {
    logic [15:0] hour;
    logic [15:0] minute;
    logic [15:0] second;
  } tdrwa_time_type;

endpackage

// *** hw/tdrwa_time_of_day.sv ***
/*
 * Time-of-day counters with read, write and seconds-round requests.
 * Assumes the user program engine gives a one-cycle scan strobe and
 * request levels on core_clk_in, and stores the read words itself.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - read copies hour, minute, second in order
// - read serviced every scan while held
// - write loads hour, minute, second counters
// - write acts on rising edge only
// - out-of-range write raises error flag, indicator
// - error code stored when control registers enabled
// - round with seconds 0-29 clears seconds only
// - round with seconds 30-59 clears, bumps minute
// - round takes no operand, rising edge only
module tdrwa_time_of_day #(
  parameter int TICK_CYCLES = tdrwa_pkg::SEC_CYCLES  // Cycles per second
) (
  input  wire logic                      core_clk_in,   // Core clock
  input  wire logic                      rst_in,        // Sync reset
  input  wire logic                      scan_in,       // Scan strobe
  input  wire logic                      time_read_request_in,
  input  wire logic [6:0]                read_base_in,  // First register
  input  wire logic                      time_write_request_in,
  input  wire tdrwa_pkg::tdrwa_time_type write_data_in, // Source words
  input  wire logic                      seconds_round_request_in,
  input  wire logic                      control_register_enable_function_in,
  input  wire logic                      exec_error_clear_in,
  output logic                           read_valid_out,  // Word pulse
  output logic [6:0]                     read_base_out,
  output tdrwa_pkg::tdrwa_time_type      read_data_out,
  output tdrwa_pkg::tdrwa_time_type      time_now_out,
  output logic                           exec_error_flag_out,
  output logic                           error_indicator_out,
  output logic [15:0]                    error_code_slot_out
);

  // ***************************************************************
  // Request decode
  // ***************************************************************
  logic wr_fire;   // Write edge seen at a scan
  logic adj_fire;  // Round edge seen at a scan
  logic rd_fire;   // Read level seen at a scan
  logic wr_ok;     // All written fields in range

  // Edge detect for the write request
  tdrwa_edge u_wr_edge (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .scan_in     (scan_in),
    .level_in    (time_write_request_in),
    .rise_out    (wr_fire)
  );

  // Edge detect for the round request; no operand is taken
  tdrwa_edge u_adj_edge (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .scan_in     (scan_in),
    .level_in    (seconds_round_request_in),
    .rise_out    (adj_fire)
  );

  // Level-acting read, once per scan
  assign rd_fire = scan_in & time_read_request_in;

  // Full 16-bit compare, so high garbage bits are caught too
  assign wr_ok = (write_data_in.hour   <= tdrwa_pkg::HOUR_MAX) &&
                 (write_data_in.minute <= tdrwa_pkg::MIN_MAX)  &&
                 (write_data_in.second <= tdrwa_pkg::SEC_MAX);

  // ***************************************************************
  // Timebase
  // ***************************************************************
  logic [31:0] tick_cnt_r;  // Cycles into the current second
  logic        sec_tick;    // Last cycle of the second

  assign sec_tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // Restarted by valid write and round, so the new second is a full one
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if ((wr_fire && wr_ok) || adj_fire || sec_tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // ***************************************************************
  // Time counters
  // ***************************************************************
  logic [15:0] hour_r;  // 0..23
  logic [15:0] min_r;   // 0..59
  logic [15:0] sec_r;   // 0..59
  logic [15:0] min_inc; // Minute plus one, wrapped
  logic [15:0] hour_inc;// Hour plus one, wrapped

  // Wrap helpers shared by the tick and the round-up
  assign min_inc  = (min_r == tdrwa_pkg::MIN_MAX) ? 16'h0000 :
                    min_r + 16'h0001;
  assign hour_inc = (hour_r == tdrwa_pkg::HOUR_MAX) ? 16'h0000 :
                    hour_r + 16'h0001;

  // Priority: valid write, then round, then the second tick.
  // A tick coinciding with a valid write or round is absorbed by it.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hour_r <= tdrwa_pkg::RST_HOUR;
      min_r  <= tdrwa_pkg::RST_MIN;
      sec_r  <= tdrwa_pkg::RST_SEC;
    end else if (wr_fire && wr_ok) begin
      // Bad data leaves the clock untouched
      hour_r <= write_data_in.hour;
      min_r  <= write_data_in.minute;
      sec_r  <= write_data_in.second;
    end else if (adj_fire) begin
      sec_r <= 16'h0000;
      if (sec_r >= tdrwa_pkg::SEC_ROUND_UP) begin
        // Round up into the next minute
        min_r <= min_inc;
        if (min_r == tdrwa_pkg::MIN_MAX) begin
          hour_r <= hour_inc;
        end
      end
    end else if (sec_tick) begin
      if (sec_r == tdrwa_pkg::SEC_MAX) begin
        sec_r <= 16'h0000;
        min_r <= min_inc;
        if (min_r == tdrwa_pkg::MIN_MAX) begin
          hour_r <= hour_inc;
        end
      end else begin
        sec_r <= sec_r + 16'h0001;
      end
    end
  end

  // Live time, for display and comparison logic
  assign time_now_out = '{hour: hour_r, minute: min_r, second: sec_r};

  // ***************************************************************
  // Read port
  // ***************************************************************
  // Registered copy; word order hour, minute, second
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      read_valid_out <= 1'b0;
      read_base_out  <= 7'h00;
      read_data_out  <= '0;
    end else begin
      read_valid_out <= rd_fire;
      if (rd_fire) begin
        read_base_out <= read_base_in;
        read_data_out <= time_now_out;
      end
    end
  end

  // ***************************************************************
  // Error reporting
  // ***************************************************************
  logic err_set;  // Failed write this cycle

  assign err_set = wr_fire && !wr_ok;

  // Sticky flag; a new failure beats a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      exec_error_flag_out <= 1'b0;
    end else if (err_set) begin
      exec_error_flag_out <= 1'b1;
    end else if (exec_error_clear_in) begin
      exec_error_flag_out <= 1'b0;
    end
  end

  // Indicator follows the flag
  assign error_indicator_out = exec_error_flag_out;

  // Code slot written only while control registers are enabled
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      error_code_slot_out <= tdrwa_pkg::RST_CODE;
    end else if (err_set && control_register_enable_function_in) begin
      error_code_slot_out <= tdrwa_pkg::ERR_TIME_RANGE;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  logic wr_last_h;  // Write level at previous scan
  logic adj_last_h; // Round level at previous scan

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_last_h  <= 1'b0;
      adj_last_h <= 1'b0;
    end else if (scan_in) begin
      wr_last_h  <= time_write_request_in;
      adj_last_h <= seconds_round_request_in;
    end
  end

  a_read_copy: assert property (p_read_copy)
    else $error("read words differ from time");
  property p_read_copy;
    @(posedge core_clk_in) disable iff (rst_in)
    rd_fire |=> read_valid_out && read_data_out == $past(time_now_out);
  endproperty

  a_read_level: assert property (p_read_level)
    else $error("read pulse not tied to held request");
  property p_read_level;
    @(posedge core_clk_in) disable iff (rst_in)
    read_valid_out == $past(scan_in && time_read_request_in);
  endproperty

  a_write_load: assert property (p_write_load)
    else $error("valid write not loaded");
  property p_write_load;
    @(posedge core_clk_in) disable iff (rst_in)
    wr_fire && wr_ok |=> time_now_out == $past(write_data_in);
  endproperty

  a_write_edge: assert property (p_write_edge)
    else $error("write fired without rising edge");
  property p_write_edge;
    @(posedge core_clk_in) disable iff (rst_in)
    wr_fire == (scan_in && time_write_request_in && !wr_last_h);
  endproperty

  a_err_flag: assert property (p_err_flag)
    else $error("bad write did not raise error");
  property p_err_flag;
    @(posedge core_clk_in) disable iff (rst_in)
    err_set |=> exec_error_flag_out && error_indicator_out &&
      ($past(sec_tick) || time_now_out == $past(time_now_out));
  endproperty

  a_err_code: assert property (p_err_code)
    else $error("error code not stored");
  property p_err_code;
    @(posedge core_clk_in) disable iff (rst_in)
    err_set && control_register_enable_function_in |=>
      error_code_slot_out == tdrwa_pkg::ERR_TIME_RANGE;
  endproperty

  a_round_down: assert property (p_round_down)
    else $error("round down changed minute");
  property p_round_down;
    @(posedge core_clk_in) disable iff (rst_in)
    adj_fire && !wr_fire && sec_r < tdrwa_pkg::SEC_ROUND_UP |=>
      sec_r == 16'h0000 && min_r == $past(min_r) &&
      hour_r == $past(hour_r);
  endproperty

  a_round_up: assert property (p_round_up)
    else $error("round up did not bump minute");
  property p_round_up;
    @(posedge core_clk_in) disable iff (rst_in)
    adj_fire && !wr_fire && sec_r >= tdrwa_pkg::SEC_ROUND_UP |=>
      sec_r == 16'h0000 && min_r == $past(min_inc);
  endproperty

  a_round_edge: assert property (p_round_edge)
    else $error("round fired without rising edge");
  property p_round_edge;
    @(posedge core_clk_in) disable iff (rst_in)
    adj_fire == (scan_in && seconds_round_request_in && !adj_last_h);
  endproperty

  a_hour_wrap: assert property (p_hour_wrap)
    else $error("hour carry or wrap wrong");
  property p_hour_wrap;
    @(posedge core_clk_in) disable iff (rst_in)
    sec_tick && !wr_fire && !adj_fire && sec_r == tdrwa_pkg::SEC_MAX &&
    min_r == tdrwa_pkg::MIN_MAX |=> min_r == 16'h0000 &&
      hour_r == $past(hour_inc);
  endproperty

  a_sec_tick: assert property (p_sec_tick)
    else $error("seconds did not advance on tick");
  property p_sec_tick;
    @(posedge core_clk_in) disable iff (rst_in)
    sec_tick && !wr_fire && !adj_fire && sec_r != tdrwa_pkg::SEC_MAX |=>
      sec_r == $past(sec_r) + 16'h0001 && min_r == $past(min_r);
  endproperty

endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for the time-of-day block.
 * Assumes the engine model makes scans; ticks shortened to TICK cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ***************************************************************
  // Signals
  // ***************************************************************
  localparam int TICK = 64;           // Short second keeps the run brief
  logic                      core_clk_in, rst_in, scan, rd, wr, seconds_round_request;
  logic                      cen, clr, rvalid, eflag, eind;
  logic [6:0]                base, rbase;
  logic [7:0]                rcount;
  logic [15:0]               ecode;
  tdrwa_pkg::tdrwa_time_type wdata, rdata, tnow;
  int                        n_fail, checks_done;

  tdrwa_time_of_day #(.TICK_CYCLES(TICK)) i_tdrwa_time_of_day (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .scan_in(scan),
    .time_read_request_in(rd), .read_base_in(base),
    .time_write_request_in(wr), .write_data_in(wdata),
    .seconds_round_request_in(seconds_round_request),
    .control_register_enable_function_in(cen),
    .exec_error_clear_in(clr), .read_valid_out(rvalid),
    .read_base_out(rbase), .read_data_out(rdata), .time_now_out(tnow),
    .exec_error_flag_out(eflag), .error_indicator_out(eind),
    .error_code_slot_out(ecode));

  tdrwa_engine_model i_tdrwa_engine_model (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .read_valid_in(rvalid),
    .read_base_in(rbase), .read_data_in(rdata), .scan_out(scan),
    .read_count_out(rcount));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [47:0] t(input int h, input int m, input int s);
    return {16'(h), 16'(m), 16'(s)};
  endfunction

  // Level held over two scans, then low over two more
  task automatic op(input int k, input logic [47:0] d);
    wdata <= d;
    if (k == 0) rd <= 1'h1;
    else if (k == 1) wr <= 1'h1;
    else seconds_round_request <= 1'h1;
    repeat (4) @(posedge core_clk_in);
    rd <= 1'h0;
    wr <= 1'h0;
    seconds_round_request <= 1'h0;
    repeat (4) @(posedge core_clk_in);
  endtask

  task automatic test_done;
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Held write loads once; data changed mid-hold must not land
  task automatic t_write;
    wdata <= t(15, 30, 0);
    wr <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    wdata <= t(7, 7, 7);
    repeat (2) @(posedge core_clk_in);
    wr <= 1'h0;
    repeat (4) @(posedge core_clk_in);
    chk(tnow, t(15, 30, 0));
  endtask

  // Held read stores on each scan, block kept low in the map
  task automatic t_read;
    logic [7:0] c0;
    c0 = rcount;
    base <= 7'h14;
    op(0, 48'h0);
    chk(rcount - c0, 48'h2);
    chk({i_tdrwa_engine_model.data_r[20], i_tdrwa_engine_model.data_r[21],
         i_tdrwa_engine_model.data_r[22]}, t(15, 30, 0));
  endtask

  // Each field out of range in turn; code stored only when enabled
  task automatic t_err;
    logic [47:0] bad [3];
    bad = '{t(24, 0, 0), t(0, 60, 0), t(0, 0, 60)};
    op(1, t(1, 2, 3));
    for (int i = 0; i < 3; i++) begin
      clr <= 1'h1;
      cen <= (i != 0);
      @(posedge core_clk_in);
      clr <= 1'h0;
      // Clear seen on the edge before, so the flag must read low now
      @(posedge core_clk_in);
      chk(eflag, 48'h0);
      op(1, bad[i]);
      chk(tnow, t(1, 2, 3));
      chk({eflag, eind, ecode},
          {2'h3, (i == 0) ? tdrwa_pkg::RST_CODE :
                            tdrwa_pkg::ERR_TIME_RANGE});
    end
  endtask

  task automatic rnd(input logic [47:0] s, input logic [47:0] e);
    op(1, s);
    op(2, 48'h0);
    chk(tnow, e);
  endtask

  // Seconds ticking with carries through minute and hour
  task automatic t_tick;
    op(1, t(0, 59, 58));
    repeat (2 * TICK + TICK / 2) @(posedge core_clk_in);
    chk(tnow, t(1, 0, 0));
  endtask

  // ***************************************************************
  // Clock, reset, sequence, watchdog
  // ***************************************************************
  initial begin
    core_clk_in = 1'h0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  initial begin
    {rd, wr, seconds_round_request, cen, clr} = 5'h00;
    base = 7'h00;
    wdata = 48'h0;
    n_fail = 0;
    checks_done = 0;
    rst_in = 1'h1;
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'h0;
    @(posedge core_clk_in);
    chk(tnow, 48'h0);
    chk({eflag, eind, ecode}, 48'h0);
    t_write();
    t_read();
    t_err();
    rnd(t(10, 20, 29), t(10, 20, 0));
    rnd(t(10, 20, 30), t(10, 21, 0));
    rnd(t(23, 59, 45), t(0, 0, 0));
    t_tick();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    test_done();
  end
endmodule

`default_nettype wire

// *** verif/tdrwa_engine_model.sv ***
/*
 * Engine model: scan strobe and data registers that take read words.
 * Assumes one core clock shared with tdrwa_time_of_day.
 */
`timescale 1ns/1ps
`default_nettype none

module tdrwa_engine_model (
  input  wire logic                      core_clk_in,    // Core clock
  input  wire logic                      rst_in,         // Sync reset
  input  wire logic                      read_valid_in,  // Word pulse
  input  wire logic [6:0]                read_base_in,   // First register
  input  wire tdrwa_pkg::tdrwa_time_type read_data_in,   // Read words
  output logic                           scan_out,       // Scan strobe
  output logic [7:0]                     read_count_out  // Reads taken
);
  // ***************************************************************
  // Scan and store
  // ***************************************************************
  logic [15:0] data_r [0:101];  // Data registers, block may end at 101

  // Scan every other cycle, so a level held two cycles may miss none
  always_ff @(posedge core_clk_in) begin
    if (rst_in) scan_out <= 1'h0;
    else scan_out <= ~scan_out;
  end

  // Each pulse stores a whole block: hour, minute, second
  always_ff @(posedge core_clk_in) begin
    if (read_valid_in) begin
      data_r[read_base_in]        <= read_data_in.hour;
      data_r[read_base_in + 7'h1] <= read_data_in.minute;
      data_r[read_base_in + 7'h2] <= read_data_in.second;
    end
  end

  // Count pulses so the bench sees one store per scan
  always_ff @(posedge core_clk_in) begin
    if (rst_in) read_count_out <= 8'h00;
    else if (read_valid_in) read_count_out <= read_count_out + 8'h01;
  end
endmodule

`default_nettype wire
